// >>> rtl/rcp_pkg.sv
// Shared constants, state types and character helpers of the radio
// command link. Assumes both ends share one clock and one reset.
package rcp_pkg;
	// Framing characters
	localparam logic [7:0] ASC_CMD   = 8'h40;
	localparam logic [7:0] ASC_RSP   = 8'h2A;
	localparam logic [7:0] ASC_CR    = 8'h0D;
	localparam logic [7:0] ASC_LF    = 8'h0A;
	localparam logic [7:0] ASC_EQ    = 8'h3D;
	localparam logic [7:0] ASC_SLASH = 8'h2F;
	localparam logic [7:0] ASC_W     = 8'h57;
	localparam logic [7:0] ASC_COMMA = 8'h2C;
	localparam logic [7:0] ASC_0     = 8'h30;
	localparam logic [7:0] ASC_9     = 8'h39;
	localparam logic [7:0] ASC_UA    = 8'h41;
	localparam logic [7:0] ASC_UF    = 8'h46;
	localparam logic [7:0] ASC_LA    = 8'h61;
	localparam logic [7:0] ASC_LZ    = 8'h7A;
	localparam logic [7:0] ASC_AOFS  = 8'h37;
	localparam logic [7:0] CASE_MASK = 8'hDF;
	// Two-character names, upper case
	localparam logic [15:0] NM_TXDATA = 16'h4454;
	localparam logic [15:0] NM_RXDATA = 16'h4452;
	localparam logic [15:0] NM_LEVEL  = 16'h5253;
	localparam logic [15:0] NM_ERR    = 16'h4552;
	localparam logic [15:0] NM_STORE  = 16'h5752;
	localparam logic [15:0] VAL_STORE_OK = 16'h5053;
	localparam logic [15:0] ID_RESERVED  = 16'hFFFF;
	// Error value for unknown or malformed commands (arbitrary)
	localparam logic [15:0] ERR_CODE  = 16'h0001;
	// Value digit counts
	localparam logic [2:0] ND_NONE = 3'h0;
	localparam logic [2:0] ND_BYTE = 3'h2;
	localparam logic [2:0] ND_WORD = 3'h4;
	// Settings table; indices 1..3 hold four-digit identifiers
	localparam int NSET = 12;
	localparam logic [3:0] IDX_CHAN = 4'h0;
	localparam logic [3:0] IDX_TXID = 4'h1;
	localparam logic [3:0] IDX_RXID = 4'h2;
	localparam logic [3:0] IDX_SYSID = 4'h3;
	localparam logic [15:0] SET_NAME [NSET] = '{16'h4348, 16'h4954,
		16'h4952, 16'h4953, 16'h4252, 16'h5042, 16'h5342, 16'h4D44,
		16'h5443, 16'h5442, 16'h4354, 16'h454D};
	localparam logic [15:0] SET_DEFAULT = 16'h0000;

	typedef enum logic [2:0] {P_IDLE = 3'h0, P_NAME1 = 3'h1,
		P_NAME2 = 3'h3, P_VAL = 3'h2, P_DATA = 3'h6, P_LF = 3'h7,
		P_EXEC = 3'h5} rcp_prs_e;
	typedef enum logic [3:0] {O_IDLE = 4'h0, O_PFX = 4'h1, O_N1 = 4'h3,
		O_N2 = 4'h2, O_EQ = 4'h6, O_VAL = 4'h7, O_RAW = 4'h5,
		O_CR = 4'h4, O_LF = 4'hC, O_WAIT = 4'hD, O_SL = 4'hF,
		O_W = 4'hE} rcp_out_e;

	function automatic logic [7:0] rcp_upcase(input logic [7:0] c);
		return (c >= ASC_LA && c <= ASC_LZ) ? (c & CASE_MASK) : c;
	endfunction

	function automatic logic rcp_is_hex(input logic [7:0] c);
		logic [7:0] u;
		u = rcp_upcase(c);
		return (c >= ASC_0 && c <= ASC_9) || (u >= ASC_UA && u <= ASC_UF);
	endfunction

	function automatic logic [3:0] rcp_hex_val(input logic [7:0] c);
		logic [7:0] d;
		d = (c <= ASC_9) ? (c - ASC_0) : (rcp_upcase(c) - ASC_AOFS);
		return d[3:0];
	endfunction

	function automatic logic [7:0] rcp_to_hex(input logic [3:0] n);
		return (n < 4'hA) ? (ASC_0 + {4'h0, n}) : (ASC_AOFS + {4'h0, n});
	endfunction
endpackage

// >>> rtl/rcp_link_if.sv
// Byte link between host controller and radio module, with flow control.
// Assumes one byte per cycle at most and a shared clock at both ends.
`timescale 1ns/1ps
`default_nettype none
interface rcp_link_if;
	logic [7:0] h2d_data;
	logic       h2d_valid;
	logic [7:0] d2h_data;
	logic       d2h_valid;
	logic       rts_n;
	logic       cts_n;
	modport dev (input h2d_data, h2d_valid, cts_n,
		output d2h_data, d2h_valid, rts_n);
	modport host (output h2d_data, h2d_valid, cts_n,
		input d2h_data, d2h_valid, rts_n);
endinterface
`default_nettype wire

// >>> rtl/rcp_dev.sv
// Radio module end: command parser, settings store and response framer.
// Assumes the host keeps one command in flight and obeys rts_n.
`timescale 1ns/1ps
`default_nettype none
module rcp_dev
	import rcp_pkg::*;
(
	// Clock and resets
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        por_n,
	// Host link
	rcp_link_if.dev          link,
	// Radio transmit side
	output logic             tx_start,
	output logic [7:0]       tx_len,
	output logic             tx_valid,
	output logic [7:0]       tx_byte,
	// Radio receive side
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_end,
	input  wire logic        rx_ok,
	input  wire logic [7:0]  rssi,
	output logic             rx_ready,
	// Applied settings
	output logic [15:0]      cfg_channel,
	output logic [15:0]      cfg_tx_ident,
	output logic [15:0]      cfg_rx_ident,
	output logic [15:0]      cfg_sys_ident
);
	rcp_prs_e    pst_q;
	rcp_out_e    ost_q;
	logic [15:0] name_q, acc_q, set_q [NSET], nv_q [NSET];
	logic [2:0]  ndig_q;
	logic        stop_q, slash_q, pers_q, bad_q;
	logic [7:0]  cnt_q, hb, obyte, k_q, rxw_q, dr_len_q, o_raw_q;
	logic [7:0]  rxbuf [256];
	logic [15:0] o_name_q, o_val_q, p_name_q, p_val_q;
	logic [2:0]  o_nd_q, p_nd_q, sel;
	logic        o_lit_q, pend_q, drq_q, rx_ready_q, rts_n_q;
	logic        d2h_valid_q, tx_start_q, tx_valid_q;
	logic [7:0]  d2h_data_q, tx_len_q, tx_byte_q;
	logic        hit, wide, do_set, r_pers, go, fire, dr_start, len_done;
	logic [3:0]  eidx;
	logic [15:0] r_name, r_val;
	logic [2:0]  r_nd;

	assign hb = link.h2d_data;
	assign link.d2h_data  = d2h_data_q;
	assign link.d2h_valid = d2h_valid_q;
	assign link.rts_n     = rts_n_q;
	assign tx_start = tx_start_q;
	assign tx_len   = tx_len_q;
	assign tx_valid = tx_valid_q;
	assign tx_byte  = tx_byte_q;
	assign rx_ready = rx_ready_q;
	assign cfg_channel   = set_q[IDX_CHAN];
	assign cfg_tx_ident  = set_q[IDX_TXID];
	assign cfg_rx_ident  = set_q[IDX_RXID];
	assign cfg_sys_ident = set_q[IDX_SYSID];

	// Second length digit of a transmit command
	assign len_done = link.h2d_valid && pst_q == P_VAL && hb != ASC_CR
		&& name_q == NM_TXDATA && !stop_q && !slash_q
		&& ndig_q == 3'h1 && rcp_is_hex(hb);

	// Raw payload bytes may equal the prefix, so no restart in P_DATA
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pst_q <= P_IDLE;
			name_q <= 16'h0000;
			acc_q <= 16'h0000;
			ndig_q <= ND_NONE;
			{stop_q, slash_q, pers_q, bad_q} <= 4'h0;
			cnt_q <= 8'h00;
		end
		else if (pst_q == P_EXEC)
		begin
			if (go)
				pst_q <= P_IDLE;
		end
		else if (link.h2d_valid)
		begin
			if (hb == ASC_CMD && pst_q != P_DATA)
			begin
				pst_q <= P_NAME1;
				acc_q <= 16'h0000;
				ndig_q <= ND_NONE;
				{stop_q, slash_q, pers_q, bad_q} <= 4'h0;
			end
			else
			begin
				case (pst_q)
					P_NAME1:
					begin
						name_q[15:8] <= rcp_upcase(hb);
						pst_q <= P_NAME2;
					end
					P_NAME2:
					begin
						name_q[7:0] <= rcp_upcase(hb);
						pst_q <= P_VAL;
					end
					P_VAL:
					begin
						if (hb == ASC_CR)
							pst_q <= P_LF;
						else if (len_done)
						begin
							acc_q <= {acc_q[11:0], rcp_hex_val(hb)};
							ndig_q <= ND_BYTE;
							stop_q <= 1'b1;
							cnt_q <= {acc_q[3:0], rcp_hex_val(hb)};
							if ({acc_q[3:0], rcp_hex_val(hb)} != 8'h00)
								pst_q <= P_DATA;
						end
						else if (slash_q)
						begin
							pers_q <= (hb == ASC_W);
							bad_q <= bad_q | (hb != ASC_W);
							slash_q <= 1'b0;
						end
						else if (hb == ASC_SLASH)
						begin
							slash_q <= 1'b1;
							stop_q <= 1'b1;
						end
						else if (hb == ASC_COMMA || stop_q)
							stop_q <= 1'b1;
						else if (rcp_is_hex(hb) && ndig_q < ND_WORD)
						begin
							acc_q <= {acc_q[11:0], rcp_hex_val(hb)};
							ndig_q <= ndig_q + 3'h1;
						end
						else
							bad_q <= 1'b1;
					end
					P_DATA:
					begin
						cnt_q <= cnt_q - 8'h01;
						if (cnt_q == 8'h01)
							pst_q <= P_VAL;
					end
					P_LF:
						pst_q <= (hb == ASC_LF) ? P_EXEC : P_IDLE;
					default:
						pst_q <= P_IDLE;
				endcase
			end
		end
	end

	// Payload to the radio; reserved identifier keeps the radio silent
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			{tx_start_q, tx_valid_q} <= 2'h0;
			tx_len_q <= 8'h00;
			tx_byte_q <= 8'h00;
		end
		else
		begin
			tx_start_q <= len_done && set_q[IDX_TXID] != ID_RESERVED;
			if (len_done)
				tx_len_q <= {acc_q[3:0], rcp_hex_val(hb)};
			tx_valid_q <= link.h2d_valid && pst_q == P_DATA
				&& set_q[IDX_TXID] != ID_RESERVED;
			tx_byte_q <= hb;
		end
	end

	always_comb
	begin
		hit = 1'b0;
		eidx = 4'h0;
		for (int i = 0; i < NSET; i++)
			if (name_q == SET_NAME[i])
			begin
				hit = 1'b1;
				eidx = 4'(i);
			end
	end
	assign wide = eidx >= IDX_TXID && eidx <= IDX_SYSID;

	// Malformed values and store on other commands fall to the error reply
	always_comb
	begin
		r_name = NM_ERR;
		r_val = ERR_CODE;
		r_nd = ND_BYTE;
		r_pers = 1'b0;
		do_set = 1'b0;
		if (bad_q)
			r_name = NM_ERR;
		else if (name_q == NM_TXDATA && ndig_q == ND_BYTE && !pers_q)
		begin
			r_name = NM_TXDATA;
			r_val = acc_q;
		end
		else if (name_q == NM_LEVEL && ndig_q == ND_NONE && !pers_q)
		begin
			r_name = NM_LEVEL;
			r_val = {8'h00, rssi};
		end
		else if (hit && (ndig_q == ND_NONE
			|| ndig_q == (wide ? ND_WORD : ND_BYTE)))
		begin
			r_name = name_q;
			r_nd = wide ? ND_WORD : ND_BYTE;
			r_val = (ndig_q == ND_NONE) ? set_q[eidx] : acc_q;
			r_pers = pers_q;
			do_set = ndig_q != ND_NONE;
		end
	end

	assign go = pst_q == P_EXEC && ost_q == O_IDLE && !pend_q;
	assign dr_start = ost_q == O_IDLE && !pend_q && !go && drq_q;
	assign fire = ost_q != O_IDLE && !link.cts_n;

	// Settings and their nonvolatile image
	always_ff @(posedge clk_sys)
	begin
		if (!por_n)
		begin
			for (int i = 0; i < NSET; i++)
				nv_q[i] <= SET_DEFAULT;
		end
		else if (go && r_pers)
			nv_q[eidx] <= r_val;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NSET; i++)
				set_q[i] <= nv_q[i];
		end
		else if (go && do_set)
			set_q[eidx] <= r_val;
	end

	// Received frame buffer; an errored frame is simply forgotten
	always_ff @(posedge clk_sys)
	begin
		if (rx_valid && rx_ready_q)
			rxbuf[rxw_q] <= rx_byte;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rxw_q <= 8'h00;
			drq_q <= 1'b0;
			dr_len_q <= 8'h00;
			rx_ready_q <= 1'b1;
		end
		else
		begin
			if (rx_end)
				rxw_q <= 8'h00;
			else if (rx_valid && rx_ready_q)
				rxw_q <= rxw_q + 8'h01;
			// Clear never skipped on a frame end, else the reply goes twice
			if (dr_start)
				drq_q <= 1'b0;
			rx_ready_q <= !drq_q
				&& (ost_q == O_IDLE || o_name_q != NM_RXDATA);
			if (rx_end && rx_ok && rxw_q != 8'h00 && rx_ready_q
				&& set_q[IDX_RXID] != ID_RESERVED)
			begin
				drq_q <= 1'b1;
				dr_len_q <= rxw_q;
				rx_ready_q <= 1'b0;
			end
		end
	end

	// Response framer
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ost_q <= O_IDLE;
			{o_name_q, o_val_q, p_name_q, p_val_q} <= 64'h0;
			{o_nd_q, p_nd_q} <= 6'h0;
			{o_lit_q, pend_q} <= 2'h0;
			o_raw_q <= 8'h00;
			k_q <= 8'h00;
		end
		else if (ost_q == O_IDLE)
		begin
			k_q <= 8'h00;
			o_raw_q <= 8'h00;
			o_lit_q <= 1'b0;
			if (pend_q)
			begin
				ost_q <= O_PFX;
				{o_name_q, o_val_q, o_nd_q} <= {p_name_q, p_val_q, p_nd_q};
				pend_q <= 1'b0;
			end
			else if (go && r_pers)
			begin
				ost_q <= O_PFX;
				{o_name_q, o_val_q, o_nd_q} <= {NM_STORE, VAL_STORE_OK, ND_BYTE};
				o_lit_q <= 1'b1;
				{p_name_q, p_val_q, p_nd_q} <= {r_name, r_val, r_nd};
				pend_q <= 1'b1;
			end
			else if (go)
			begin
				ost_q <= O_PFX;
				{o_name_q, o_val_q, o_nd_q} <= {r_name, r_val, r_nd};
			end
			else if (dr_start)
			begin
				ost_q <= O_PFX;
				{o_name_q, o_val_q, o_nd_q} <= {NM_RXDATA, 8'h00, dr_len_q, ND_BYTE};
				o_raw_q <= dr_len_q;
			end
		end
		else if (fire)
		begin
			case (ost_q)
				O_PFX: ost_q <= O_N1;
				O_N1:  ost_q <= O_N2;
				O_N2:  ost_q <= O_EQ;
				O_EQ:  ost_q <= O_VAL;
				O_VAL:
				begin
					k_q <= k_q + 8'h01;
					if (k_q[2:0] == o_nd_q - 3'h1)
					begin
						k_q <= 8'h00;
						ost_q <= (o_raw_q != 8'h00) ? O_RAW : O_CR;
					end
				end
				O_RAW:
				begin
					k_q <= k_q + 8'h01;
					if (k_q == o_raw_q - 8'h01)
						ost_q <= O_CR;
				end
				O_CR: ost_q <= O_LF;
				default: ost_q <= O_IDLE;
			endcase
		end
	end

	assign sel = o_nd_q - 3'h1 - k_q[2:0];

	always_comb
	begin
		case (ost_q)
			O_PFX: obyte = ASC_RSP;
			O_N1:  obyte = o_name_q[15:8];
			O_N2:  obyte = o_name_q[7:0];
			O_EQ:  obyte = ASC_EQ;
			O_VAL: obyte = o_lit_q ? o_val_q[{sel[0], 3'h0} +: 8]
				: rcp_to_hex(o_val_q[{sel[1:0], 2'h0} +: 4]);
			O_RAW: obyte = rxbuf[k_q];
			O_CR:  obyte = ASC_CR;
			O_LF:  obyte = ASC_LF;
			default: obyte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			d2h_valid_q <= 1'b0;
			d2h_data_q <= 8'h00;
			rts_n_q <= 1'b1;
		end
		else
		begin
			d2h_valid_q <= fire;
			d2h_data_q <= obyte;
			rts_n_q <= pst_q == P_LF || pst_q == P_EXEC;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/rcp_host.sv
// Host controller end: frames one command at a time and decodes responses.
// Assumes the module end answers every command; a store of a setting is answered twice, WR first, a refused store once.
`timescale 1ns/1ps
`default_nettype none
module rcp_host
	import rcp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Module link
	rcp_link_if.host         link,
	// Command request
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_name,
	input  wire logic [15:0] cmd_val,
	input  wire logic [2:0]  cmd_nd,
	input  wire logic        cmd_pers,
	input  wire logic [7:0]  cmd_raw,
	input  wire logic [7:0]  pay_byte,
	input  wire logic        hold_out,
	output logic             cmd_ready,
	output logic             pay_take,
	// Responses
	output logic             rsp_valid,
	output logic [15:0]      rsp_name,
	output logic [15:0]      rsp_val,
	output logic             dr_valid,
	output logic [7:0]       dr_byte
);
	rcp_out_e    hst_q;
	rcp_prs_e    rst_q;
	logic [15:0] c_name_q, c_val_q, r_val_q, rn_q;
	logic [2:0]  c_nd_q, rnd_q, sel;
	logic        c_pers_q, send, h_valid_q, take_q, cts_q, rdy_q;
	logic        rsp_q, drv_q;
	logic [7:0]  c_raw_q, k_q, hbyte, h_data_q, rcnt_q, drb_q, db;

	assign link.h2d_data  = h_data_q;
	assign link.h2d_valid = h_valid_q;
	assign link.cts_n     = cts_q;
	assign cmd_ready = rdy_q;
	assign pay_take  = take_q;
	assign rsp_valid = rsp_q;
	assign rsp_name  = rn_q;
	assign rsp_val   = r_val_q;
	assign dr_valid  = drv_q;
	assign dr_byte   = drb_q;
	assign db = link.d2h_data;

	// One byte per free cycle; payload waits a cycle for the next byte
	assign send = hst_q != O_IDLE && hst_q != O_WAIT && !link.rts_n
		&& !(hst_q == O_RAW && take_q);
	assign sel = c_nd_q - 3'h1 - k_q[2:0];

	always_comb
	begin
		case (hst_q)
			O_PFX: hbyte = ASC_CMD;
			O_N1:  hbyte = c_name_q[15:8];
			O_N2:  hbyte = c_name_q[7:0];
			O_VAL: hbyte = rcp_to_hex(c_val_q[{sel[1:0], 2'h0} +: 4]);
			O_RAW: hbyte = pay_byte;
			O_SL:  hbyte = ASC_SLASH;
			O_W:   hbyte = ASC_W;
			O_CR:  hbyte = ASC_CR;
			O_LF:  hbyte = ASC_LF;
			default: hbyte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			hst_q <= O_IDLE;
			{c_name_q, c_val_q} <= 32'h0;
			{c_nd_q, c_pers_q} <= 4'h0;
			{c_raw_q, k_q} <= 16'h0;
		end
		else if (hst_q == O_IDLE)
		begin
			k_q <= 8'h00;
			if (cmd_valid)
			begin
				hst_q <= O_PFX;
				{c_name_q, c_val_q, c_nd_q} <= {cmd_name, cmd_val, cmd_nd};
				c_pers_q <= cmd_pers;
				c_raw_q <= cmd_raw;
			end
		end
		else if (hst_q == O_WAIT)
		begin
			// The module answers in upper case whatever case was sent
			if (rsp_q && (rn_q == {rcp_upcase(c_name_q[15:8]),
				rcp_upcase(c_name_q[7:0])} || rn_q == NM_ERR))
				hst_q <= O_IDLE;
		end
		else if (send)
		begin
			case (hst_q)
				O_PFX: hst_q <= O_N1;
				O_N1:  hst_q <= O_N2;
				O_N2:  hst_q <= (c_nd_q != ND_NONE) ? O_VAL
					: (c_pers_q ? O_SL : O_CR);
				O_VAL:
				begin
					k_q <= k_q + 8'h01;
					if (k_q[2:0] == c_nd_q - 3'h1)
					begin
						k_q <= 8'h00;
						hst_q <= (c_raw_q != 8'h00) ? O_RAW
							: (c_pers_q ? O_SL : O_CR);
					end
				end
				O_RAW:
				begin
					k_q <= k_q + 8'h01;
					if (k_q == c_raw_q - 8'h01)
						hst_q <= O_CR;
				end
				O_SL: hst_q <= O_W;
				O_W:  hst_q <= O_CR;
				O_CR: hst_q <= O_LF;
				default: hst_q <= O_WAIT;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			{h_valid_q, take_q, cts_q, rdy_q} <= 4'h0;
			h_data_q <= 8'h00;
		end
		else
		begin
			h_valid_q <= send;
			h_data_q <= hbyte;
			take_q <= send && hst_q == O_RAW;
			cts_q <= hold_out;
			rdy_q <= hst_q == O_IDLE && !cmd_valid;
		end
	end

	// Response decoder; hex digits fold into the value, letters as bytes
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rst_q <= P_IDLE;
			{rn_q, r_val_q} <= 32'h0;
			rnd_q <= ND_NONE;
			{rcnt_q, drb_q} <= 16'h0;
			{rsp_q, drv_q} <= 2'h0;
		end
		else
		begin
			rsp_q <= 1'b0;
			drv_q <= 1'b0;
			if (link.d2h_valid)
			begin
				if (db == ASC_RSP && rst_q != P_DATA)
				begin
					rst_q <= P_NAME1;
					r_val_q <= 16'h0000;
					rnd_q <= ND_NONE;
				end
				else
				begin
					case (rst_q)
						P_NAME1:
						begin
							rn_q[15:8] <= db;
							rst_q <= P_NAME2;
						end
						P_NAME2:
						begin
							rn_q[7:0] <= db;
							rst_q <= P_VAL;
						end
						P_VAL:
						begin
							if (db == ASC_CR)
								rst_q <= P_LF;
							else if (db == ASC_EQ && rnd_q == ND_NONE)
								rst_q <= P_VAL;
							else
							begin
								r_val_q <= rcp_is_hex(db)
									? {r_val_q[11:0], rcp_hex_val(db)}
									: {r_val_q[7:0], db};
								rnd_q <= rnd_q + 3'h1;
								if (rn_q == NM_RXDATA && rnd_q == 3'h1
									&& {r_val_q[3:0], rcp_hex_val(db)} != 8'h00)
								begin
									rcnt_q <= {r_val_q[3:0], rcp_hex_val(db)};
									rst_q <= P_DATA;
								end
							end
						end
						P_DATA:
						begin
							drv_q <= 1'b1;
							drb_q <= db;
							rcnt_q <= rcnt_q - 8'h01;
							if (rcnt_q == 8'h01)
								rst_q <= P_VAL;
						end
						P_LF:
						begin
							rst_q <= P_IDLE;
							rsp_q <= db == ASC_LF;
						end
						default:
							rst_q <= P_IDLE;
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/rcp_link_checker.sv
// Checker for framing and flow control on both directions of the host and module byte link.
// Assumes both ends run on clk_sys; sees only the link signals.
`timescale 1ns/1ps
`default_nettype none
module rcp_link_checker
	import rcp_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// Link
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_valid,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_valid,
	input wire logic       rts_n,
	input wire logic       cts_n
);
	logic [7:0] h_last_q;
	logic [7:0] d_last_q;
	logic [2:0] d_cnt_q;
	logic       pend_q;

	// Payloads in the bench avoid CR and LF, so the last byte marks framing
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			h_last_q <= ASC_LF;
			d_last_q <= ASC_LF;
			d_cnt_q  <= 3'h0;
			pend_q   <= 1'b0;
		end
		else
		begin
			if (h2d_valid)
				h_last_q <= h2d_data;
			if (d2h_valid)
				d_last_q <= d2h_data;
			if (d2h_valid)
				d_cnt_q <= (d2h_data == ASC_LF) ? 3'h0 :
					(d_cnt_q == 3'h4) ? 3'h4 : d_cnt_q + 3'h1;
			if (h2d_valid && h2d_data == ASC_LF)
				pend_q <= 1'b1;
			else if (d2h_valid && d2h_data == ASC_LF)
				pend_q <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_cmd_pfx;
		h2d_valid && h_last_q == ASC_LF |-> h2d_data == ASC_CMD;
	endproperty
	a_cmd_pfx: assert property (p_cmd_pfx)
		else $error("command does not open with prefix");
	property p_rsp_pfx;
		d2h_valid && d_last_q == ASC_LF |-> d2h_data == ASC_RSP;
	endproperty
	a_rsp_pfx: assert property (p_rsp_pfx)
		else $error("response does not open with prefix");
	property p_cmd_term;
		h2d_valid && h_last_q == ASC_CR |-> h2d_data == ASC_LF;
	endproperty
	a_cmd_term: assert property (p_cmd_term)
		else $error("command CR not followed by LF");
	property p_rsp_term;
		d2h_valid && d_last_q == ASC_CR |-> d2h_data == ASC_LF;
	endproperty
	a_rsp_term: assert property (p_rsp_term)
		else $error("response CR not followed by LF");
	property p_rsp_eq;
		d2h_valid && d_cnt_q == 3'h3 |-> d2h_data == ASC_EQ;
	endproperty
	a_rsp_eq: assert property (p_rsp_eq)
		else $error("fourth response byte is not equals sign");
	property p_cts_hold;
		cts_n && $past(cts_n) |-> !d2h_valid;
	endproperty
	a_cts_hold: assert property (p_cts_hold)
		else $error("output while hold requested");
	property p_rts_busy;
		h2d_valid && h2d_data == ASC_CR |-> ##[1:2] rts_n;
	endproperty
	a_rts_busy: assert property (p_rts_busy)
		else $error("accept flag not raised after CR");
	property p_rts_free;
		$rose(rts_n) |-> ##[1:1000] !rts_n;
	endproperty
	a_rts_free: assert property (p_rts_free)
		else $error("accept flag stuck high");
	property p_reply;
		h2d_valid && h2d_data == ASC_LF |->
			##[2:1000] d2h_valid && d2h_data == ASC_RSP;
	endproperty
	a_reply: assert property (p_reply)
		else $error("no response after command");
	property p_one_cmd;
		h2d_valid |-> !pend_q;
	endproperty
	a_one_cmd: assert property (p_one_cmd)
		else $error("command sent before response");

	c_store: cover property (d2h_valid && d_cnt_q == 3'h1 &&
		d2h_data == ASC_W);
	c_hold: cover property (cts_n && d_last_q != ASC_LF);
	c_recv: cover property (d2h_valid && d_cnt_q == 3'h2 &&
		d2h_data == 8'h52 && d_last_q == 8'h44);
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Bench joining host and module ends over one link, with radio stimulus.
// Assumes one 125 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb
	import rcp_pkg::*;
;
	logic        clk_sys, rst_n, por_n, cmd_valid, cmd_pers, hold_out;
	logic        cmd_ready, pay_take, rsp_valid, dr_valid, tx_start;
	logic        tx_valid, rx_valid, rx_end, rx_ok, rx_ready;
	logic [15:0] cmd_name, cmd_val, rsp_name, rsp_val, v;
	logic [2:0]  cmd_nd;
	logic [7:0]  cmd_raw, pay_byte, dr_byte, tx_len, tx_byte, rx_byte;
	logic [7:0]  rssi, pidx;
	logic [15:0] cfg [4];
	logic [7:0]  pay [256];
	logic [31:0] rq [$];
	logic [7:0]  dq [$];
	logic [7:0]  tq [$];
	int          failures, tests_run, n;

	rcp_link_if link ();
	rcp_dev i_rcp_dev (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
		.link(link.dev), .tx_start(tx_start), .tx_len(tx_len),
		.tx_valid(tx_valid), .tx_byte(tx_byte), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_end(rx_end), .rx_ok(rx_ok), .rssi(rssi),
		.rx_ready(rx_ready), .cfg_channel(cfg[0]), .cfg_tx_ident(cfg[1]),
		.cfg_rx_ident(cfg[2]), .cfg_sys_ident(cfg[3]));
	rcp_host i_rcp_host (.clk_sys(clk_sys), .rst_n(rst_n),
		.link(link.host), .cmd_valid(cmd_valid), .cmd_name(cmd_name),
		.cmd_val(cmd_val), .cmd_nd(cmd_nd), .cmd_pers(cmd_pers),
		.cmd_raw(cmd_raw), .pay_byte(pay_byte), .hold_out(hold_out),
		.cmd_ready(cmd_ready), .pay_take(pay_take), .rsp_valid(rsp_valid),
		.rsp_name(rsp_name), .rsp_val(rsp_val), .dr_valid(dr_valid),
		.dr_byte(dr_byte));
	rcp_link_checker i_rcp_link_checker (.clk_sys(clk_sys), .rst_n(rst_n),
		.h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid),
		.d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid),
		.rts_n(link.rts_n), .cts_n(link.cts_n));

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	assign pay_byte = pay[pidx];
	// The transmit length rides in tq ahead of the bytes it announces
	always @(posedge clk_sys)
	begin
		if (pay_take)
			pidx <= pidx + 8'h01;
		if (rsp_valid)
			rq.push_back({rsp_name, rsp_val});
		if (dr_valid)
			dq.push_back(dr_byte);
		if (tx_start)
			tq.push_back(tx_len);
		if (tx_valid)
			tq.push_back(tx_byte);
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_hi(ref logic s);
		int k;
		for (k = 0; s !== 1'b1 && k < 3000; k++)
			@(negedge clk_sys);
		if (s !== 1'b1)
		begin
			chk("wait", 1, 0);
			wrap_up();
		end
	endtask

	task automatic do_cmd(input logic [15:0] nm, val, input logic [2:0] nd,
		input logic p, input logic [7:0] raw);
		rq.delete();
		tq.delete();
		wait_hi(cmd_ready);
		pidx = 8'h00;
		{cmd_name, cmd_val, cmd_nd, cmd_pers, cmd_raw} = {nm, val, nd, p, raw};
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		wait_hi(cmd_ready);
		@(negedge clk_sys);
	endtask

	task automatic fill(input int cnt);
		for (int i = 0; i < cnt; i++)
			pay[i] = 8'h20 + 8'($urandom % 95);
	endtask

	task automatic rx_frame(input int cnt, input logic ok);
		dq.delete();
		rq.delete();
		for (int i = 0; i < cnt; i++)
		begin
			{rx_valid, rx_byte} = {1'b1, pay[i]};
			@(negedge clk_sys);
		end
		{rx_valid, rx_ok, rx_end} = {1'b0, ok, 1'b1};
		@(negedge clk_sys);
		rx_end = 1'b0;
		repeat (2) @(negedge clk_sys);
		wait_hi(rx_ready);
		repeat (4) @(negedge clk_sys);
	endtask

	initial
	begin
		{rst_n, por_n, cmd_valid, cmd_pers, hold_out} = 5'h00;
		{rx_valid, rx_end, rx_ok, pidx, cmd_raw} = 19'h00000;
		{cmd_name, cmd_val, cmd_nd, rx_byte} = 43'h0;
		void'($urandom(32'hB7BE8F2A));
		rssi = 8'($urandom);
		repeat (6) @(negedge clk_sys);
		por_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		for (int i = 0; i < NSET; i++)
		begin
			// Top bit cleared keeps identifiers off the reserved value
			v = 16'($urandom) & 16'h7FFF;
			n = (i >= 1 && i <= 3) ? 4 : 2;
			if (n == 2)
				v[15:8] = 8'h00;
			do_cmd(SET_NAME[i], v, 3'(n), 1'b0, 8'h00);
			chk("setting reply", {SET_NAME[i], v}, rq[$]);
			if (i < 4)
				chk("setting applied", v, cfg[i]);
		end
		$display("test settings done");
		v = {8'h00, 8'($urandom)};
		do_cmd(SET_NAME[IDX_CHAN], v, ND_BYTE, 1'b1, 8'h00);
		chk("store reply", {NM_STORE, VAL_STORE_OK}, rq[0]);
		chk("store then reply", {SET_NAME[IDX_CHAN], v}, rq[$]);
		do_cmd(16'h5A5A, 16'h0000, ND_NONE, 1'b0, 8'h00);
		chk("unknown reply", {NM_ERR, ERR_CODE}, rq[$]);
		do_cmd(NM_LEVEL, 16'h0000, ND_NONE, 1'b1, 8'h00);
		chk("store refused", {NM_ERR, ERR_CODE}, rq[$]);
		rst_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk("kept channel", v, cfg[0]);
		chk("unkept ident", SET_DEFAULT, cfg[1]);
		do_cmd(SET_NAME[IDX_CHAN] | 16'h2020, 16'h0000, ND_NONE, 1'b0, 8'h00);
		chk("lower case", {SET_NAME[IDX_CHAN], v}, rq[$]);
		$display("test store done");
		for (int j = 0; j < 4; j++)
		begin
			n = (j == 0) ? 1 : (j == 1) ? 255 : 2 + $urandom % 40;
			if (j == 3)
				do_cmd(SET_NAME[IDX_TXID], ID_RESERVED, ND_WORD, 1'b0, 8'h00);
			fill(n);
			do_cmd(NM_TXDATA, 16'(n), ND_BYTE, 1'b0, 8'(n));
			chk("transmit reply", {NM_TXDATA, 16'(n)}, rq[$]);
			chk("radio count", (j == 3) ? 0 : n + 1, tq.size());
			for (int i = 0; i < tq.size(); i++)
				chk("radio byte", i ? pay[i-1] : n, tq[i]);
		end
		$display("test transmit done");
		for (int j = 0; j < 3; j++)
		begin
			if (j == 2)
				do_cmd(SET_NAME[IDX_RXID], ID_RESERVED, ND_WORD, 1'b0, 8'h00);
			n = 1 + $urandom % 20;
			fill(n);
			rx_frame(n, j != 1);
			chk("receive replies", j == 0, rq.size());
			chk("receive count", (j == 0) ? n : 0, dq.size());
			if (j == 0)
				chk("receive head", {NM_RXDATA, 16'(n)}, rq[0]);
			for (int i = 0; i < dq.size(); i++)
				chk("receive byte", pay[i], dq[i]);
		end
		$display("test receive done");
		do_cmd(SET_NAME[IDX_CHAN], 16'h0021, ND_BYTE, 1'b0, 8'h00);
		hold_out = 1'b1;
		fork
			do_cmd(NM_LEVEL, 16'h0000, ND_NONE, 1'b0, 8'h00);
			begin
				repeat (30) @(negedge clk_sys);
				hold_out = 1'b0;
			end
		join
		chk("level reply", {NM_LEVEL, 8'h00, rssi}, rq[$]);
		$display("test level done");
		wrap_up();
	end

	initial
	begin
		repeat (100000) @(posedge clk_sys);
		chk("run length", 1, 0);
		wrap_up();
	end
endmodule
`default_nettype wire
